/* File: design/timer16_ctc_fast_pwm.sv */
// 16-bit timer with clear-on-match and fast PWM waveform generation, APB slave
`timescale 1ns/10ps
`default_nettype none
`include "timer16_cfg.svh"

// Notes on behaviour
// - In CTC, reaching TOP sets compare A flag or capture flag per variant.
// - CTC compare A is unbuffered; writing below count misses, wraps through zero.
// - CTC with output mode 1 toggles output A on every match.
// - Pad shows output state only while its direction bit selects output.
// - Toggle with compare zero flips every cycle; period 2*N*(1+compare).
// - Timer clock is peripheral clock divided by 1, 8, 64, 256 or 1024.
// - In CTC the overflow flag sets when count rolls from maximum to zero.
// - Modes 5, 6, 7, E, F run fast PWM: count zero to TOP, restart.
// - Fast PWM TOP is 0x00FF, 0x01FF, 0x03FF, capture register or compare A.
// - In fast PWM the counter clears the timer cycle after equalling TOP.
// - Non-inverting clears on match, sets at zero; inverting does the opposite.
// - TOP from 0x0003 to 0xFFFF is supported; software keeps it at least 3.
// - In fast PWM each channel flag sets when count equals its compare.
// - In fast PWM the overflow flag sets each time count reaches TOP.
// - Capture or compare A flag as TOP sets together with overflow flag.
// - Compare above TOP never matches; software keeps TOP above compares.
// - Fixed TOP masks compare bits above the resolution on every write.
// - Capture TOP is unbuffered; writing below count runs to 0xFFFF first.
// - Fast PWM compare A writes go to a buffer, loaded at TOP.
// - With capture TOP, compare A still drives a PWM duty on output A.
// - Modes 4 and C are CTC, clearing on compare A or capture match.
// - Output mode zero leaves output unchanged; reset clears output state.
module timer16_ctc_fast_pwm (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    output var timer16_pkg::pad_type  pad_a,
    output var timer16_pkg::pad_type  pad_b
);
    import timer16_pkg::*;

    state_type    s_r;
    state_type    s_nxt;
    logic [3:0]   mode;
    logic [2:0]   csel;
    logic         pwm;
    logic         ctc;
    logic         fixed_top;
    logic [15:0]  top_val;
    logic         tick;
    logic         at_top;
    logic         restart;
    logic         match_a;
    logic         match_b;
    logic         cap_hit;
    logic         ovf_set;
    logic         wr_go;
    logic         rd_go;
    logic         addr_ok;
    logic [15:0]  wval;
    logic [3:0]   fset;

    // ------------------------------------------------------------
    // Output action of one compare channel
    // ------------------------------------------------------------
    function automatic logic oc_step(input logic oc, input logic [1:0] com,
                                     input logic match, input logic rst0,
                                     input logic is_pwm, input logic tog_ok);
        logic v;
        v = oc;
        if (!is_pwm) begin
            if (match) begin
                if (com == `COM_TOG) v = ~oc;
                if (com == `COM_CLR) v = 1'b0;
                if (com == `COM_SET) v = 1'b1;
            end
        end else begin
            if (com == `COM_TOG && tog_ok && match) v = ~oc;
            if (com == `COM_CLR) begin
                if (match) v = 1'b0;
                if (rst0) v = 1'b1;                      // Set at zero wins a tie
            end
            if (com == `COM_SET) begin
                if (match) v = 1'b1;
                if (rst0) v = 1'b0;
            end
        end
        return v;
    endfunction

    // ------------------------------------------------------------
    // Mode decode, TOP selection and prescaler enable
    // ------------------------------------------------------------
    always_comb begin
        mode      = s_r.ctrl[`F_MODE];
        csel      = s_r.ctrl[`F_CSEL];
        pwm       = 1'b0;
        ctc       = 1'b0;
        fixed_top = 1'b0;
        top_val   = `MAX16;
        // TOP may be any value; values under 3 are software's fault
        case (mode)
            `M_CTC_A: begin ctc = 1'b1; top_val = s_r.cmpa_act; end
            `M_CTC_I: begin ctc = 1'b1; top_val = s_r.captop; end
            `M_FP8:   begin pwm = 1'b1; fixed_top = 1'b1; top_val = `TOP8; end
            `M_FP9:   begin pwm = 1'b1; fixed_top = 1'b1; top_val = `TOP9; end
            `M_FP10:  begin pwm = 1'b1; fixed_top = 1'b1; top_val = `TOP10; end
            `M_FP_I:  begin pwm = 1'b1; top_val = s_r.captop; end
            `M_FP_A:  begin pwm = 1'b1; top_val = s_r.cmpa_act; end
            default:  begin pwm = 1'b0; end              // Free running
        endcase
        case (csel)
            `CS_1:    tick = 1'b1;
            `CS_8:    tick = (s_r.presc == `PS_8);
            `CS_64:   tick = (s_r.presc == `PS_64);
            `CS_256:  tick = (s_r.presc == `PS_256);
            `CS_1024: tick = (s_r.presc == `PS_1024);
            default:  tick = 1'b0;                       // Stopped
        endcase
    end

    // ------------------------------------------------------------
    // Compare, TOP and wrap detection
    // ------------------------------------------------------------
    always_comb begin
        at_top  = (s_r.cnt == top_val);
        restart = (pwm || ctc) && at_top;
        // A compare above TOP never matches in PWM
        match_a = (s_r.cnt == s_r.cmpa_act) &&
                  (!pwm || s_r.cmpa_act <= top_val);
        match_b = (s_r.cnt == s_r.cmpb) &&
                  (!pwm || s_r.cmpb <= top_val);
        cap_hit = (s_r.cnt == s_r.captop) &&
                  (mode == `M_CTC_I || mode == `M_FP_I);
        // Overflow at TOP in PWM, at the maximum otherwise
        ovf_set = pwm ? at_top : (s_r.cnt == `MAX16);
    end

    // ------------------------------------------------------------
    // APB decode: one wait state so read data comes from a flop
    // ------------------------------------------------------------
    always_comb begin
        wr_go   = psel && penable && pwrite && s_r.pready;
        rd_go   = psel && penable && !s_r.pready;
        addr_ok = (paddr == `A_CTRL) || (paddr == `A_COUNT) ||
                  (paddr == `A_CMPA) || (paddr == `A_CMPB) ||
                  (paddr == `A_CAPTOP) || (paddr == `A_FLAGS);
        // Fixed TOP: bits above the resolution are dropped
        wval    = fixed_top ? (pwdata[15:0] & top_val) : pwdata[15:0];
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        // Flag events of this cycle, kept apart so a clear cannot hide them
        fset  = 4'h0;
        // Prescaler runs free while a clock is selected
        if (tick || csel == 3'h0) s_nxt.presc = `PS_ZERO;
        else s_nxt.presc = s_r.presc + `PS_ONE;
        if (tick) begin
            // CTC missing its TOP runs on to the maximum and wraps
            s_nxt.cnt = restart ? `ZERO16 : s_r.cnt + `ONE16;
            if (pwm && at_top) s_nxt.cmpa_act = s_r.cmpa_buf;
            fset[`B_OVF]  = ovf_set;
            fset[`B_CMPA] = match_a;
            fset[`B_CMPB] = match_b;
            fset[`B_CAP]  = cap_hit;
            s_nxt.flags   = s_r.flags | fset;
            s_nxt.oc_a = oc_step(s_r.oc_a, s_r.ctrl[`F_COMA], match_a,
                                 restart, pwm, mode == `M_FP_A);
            s_nxt.oc_b = oc_step(s_r.oc_b, s_r.ctrl[`F_COMB], match_b,
                                 restart, pwm, 1'b0);
        end
        // Register writes take effect at the completing edge
        if (wr_go) begin
            case (paddr)
                `A_CTRL:   s_nxt.ctrl = pwdata[`CTRL_W-1:0];
                `A_COUNT:  s_nxt.cnt = pwdata[15:0];
                `A_CMPA: begin
                    s_nxt.cmpa_buf = wval;
                    if (!pwm) s_nxt.cmpa_act = wval;
                end
                `A_CMPB:   s_nxt.cmpb = wval;
                `A_CAPTOP: s_nxt.captop = pwdata[15:0];
                // Write one to clear; an event in the same cycle wins
                `A_FLAGS:  s_nxt.flags = (s_r.flags & ~pwdata[3:0]) | fset;
                default:   begin end                     // Unmapped: ignored
            endcase
        end
        // Pads follow the output state only when driven as outputs
        s_nxt.pad_a.oe  = s_r.ctrl[`B_DIRA];
        s_nxt.pad_a.out = s_r.ctrl[`B_DIRA] & s_r.oc_a;
        s_nxt.pad_b.oe  = s_r.ctrl[`B_DIRB];
        s_nxt.pad_b.out = s_r.ctrl[`B_DIRB] & s_r.oc_b;
        // Bus answer
        s_nxt.pready  = rd_go;
        s_nxt.pslverr = rd_go && !addr_ok;
        s_nxt.prdata  = '0;
        if (rd_go && !pwrite) begin
            case (paddr)
                `A_CTRL:   s_nxt.prdata[`CTRL_W-1:0] = s_r.ctrl;
                `A_COUNT:  s_nxt.prdata[15:0] = s_r.cnt;
                `A_CMPA:   s_nxt.prdata[15:0] = s_r.cmpa_buf;
                `A_CMPB:   s_nxt.prdata[15:0] = s_r.cmpb;
                `A_CAPTOP: s_nxt.prdata[15:0] = s_r.captop;
                `A_FLAGS:  s_nxt.prdata[3:0] = s_r.flags;
                default:   s_nxt.prdata = '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) s_r <= '0;
        else s_r <= s_nxt;
    end

    // Outputs straight from flops
    assign prdata  = s_r.prdata;
    assign pready  = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign pad_a   = s_r.pad_a;
    assign pad_b   = s_r.pad_b;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_CTC_CLEAR: assert property (
        ctc && tick && at_top && !wr_go |=> s_r.cnt == `ZERO16)
        else $error("CTC count did not clear at TOP");
    AST_PWM_OVF: assert property (
        pwm && tick && at_top |=> s_r.flags[`B_OVF] && s_r.cnt == `ZERO16)
        else $error("Fast PWM overflow missing at TOP");
    AST_TOP_A_FLAGS: assert property (
        mode == `M_FP_A && tick && at_top |=> s_r.flags[`B_CMPA] && s_r.flags[`B_OVF])
        else $error("Compare A flag not with overflow");
    AST_BUF_LOAD: assert property (
        pwm && tick && at_top && !wr_go |=> s_r.cmpa_act == $past(s_r.cmpa_buf))
        else $error("Compare A buffer not loaded at TOP");
    AST_UNBUF: assert property (
        !pwm && wr_go && paddr == `A_CMPA |=> s_r.cmpa_act == $past(pwdata[15:0]))
        else $error("CTC compare A write not immediate");
    AST_TOGGLE: assert property (
        ctc && tick && match_a && s_r.ctrl[`F_COMA] == `COM_TOG
        |=> s_r.oc_a != $past(s_r.oc_a))
        else $error("Output A did not toggle");
    AST_PAD_HIDE: assert property (
        !s_r.ctrl[`B_DIRA] |=> !pad_a.oe && !pad_a.out)
        else $error("Pad A driven while input");
    AST_PWM_SET0: assert property (
        pwm && tick && restart && s_r.ctrl[`F_COMA] == `COM_CLR
        |=> s_r.oc_a ##1 pad_a.out == $past(s_r.ctrl[`B_DIRA]))
        else $error("Non-inverting output not set at zero");
    AST_STOPPED: assert property (
        !tick && !wr_go |=> s_r.cnt == $past(s_r.cnt) && s_r.flags == $past(s_r.flags))
        else $error("Timer moved without enable");
    AST_CTC_WRAP: assert property (
        ctc && tick && s_r.cnt == `MAX16 |=> s_r.flags[`B_OVF])
        else $error("CTC wrap did not set overflow");

    // Flag event and software clear in one cycle: the event must survive
    AST_FLAG_SET_WINS: assert property (
        tick && match_a && wr_go && paddr == `A_FLAGS |=> s_r.flags[`B_CMPA])
        else $error("Compare A flag lost to a clear");
    AST_PAD_SHOW_A: assert property (
        s_r.ctrl[`B_DIRA] |=> pad_a.oe && pad_a.out == $past(s_r.oc_a))
        else $error("Pad A does not show output state");
    AST_PAD_SHOW_B: assert property (
        s_r.ctrl[`B_DIRB] |=> pad_b.oe && pad_b.out == $past(s_r.oc_b))
        else $error("Pad B does not show output state");
    AST_CMP_MASK: assert property (
        fixed_top && wr_go && paddr == `A_CMPA
        |=> (s_r.cmpa_buf & ~$past(top_val)) == `ZERO16)
        else $error("Compare A bits above resolution kept");
    AST_COM_HOLD: assert property (
        tick && (match_a || restart) && s_r.ctrl[`F_COMA] == 2'h0
        |=> s_r.oc_a == $past(s_r.oc_a))
        else $error("Output A moved with output mode zero");
    AST_INV_CLEAR0: assert property (
        pwm && tick && restart && s_r.ctrl[`F_COMA] == `COM_SET |=> !s_r.oc_a)
        else $error("Inverting output not cleared at zero");
    AST_NONINV_MATCH: assert property (
        pwm && tick && match_a && !restart && s_r.ctrl[`F_COMA] == `COM_CLR
        |=> !s_r.oc_a)
        else $error("Non-inverting output not cleared on match");
    AST_CAP_TOP: assert property (
        mode == `M_FP_I && tick && at_top |=> s_r.flags[`B_CAP] && s_r.flags[`B_OVF])
        else $error("Capture flag not with overflow");
    AST_CTC_CAPFLAG: assert property (
        mode == `M_CTC_I && tick && at_top |=> s_r.flags[`B_CAP])
        else $error("CTC capture TOP did not flag");

endmodule // timer16_ctc_fast_pwm
`default_nettype wire

/* File: design/timer16_cfg.svh */
// Register map, field positions, mode codes and counts of the 16-bit PWM timer
`ifndef TIMER16_CFG_SVH
`define TIMER16_CFG_SVH

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define A_CTRL    8'h00
`define A_COUNT   8'h04
`define A_CMPA    8'h08
`define A_CMPB    8'h0c
`define A_CAPTOP  8'h10
`define A_FLAGS   8'h14

// ------------------------------------------------------------
// Control fields and flag bits
// ------------------------------------------------------------
`define CTRL_W    13
`define F_MODE    3:0
`define F_COMA    5:4
`define F_COMB    7:6
`define F_CSEL    10:8
`define B_DIRA    11
`define B_DIRB    12
`define B_OVF     0
`define B_CMPA    1
`define B_CMPB    2
`define B_CAP     3

// ------------------------------------------------------------
// Waveform mode codes, tops, output modes
// ------------------------------------------------------------
`define M_CTC_A   4'h4
`define M_FP8     4'h5
`define M_FP9     4'h6
`define M_FP10    4'h7
`define M_CTC_I   4'hc
`define M_FP_I    4'he
`define M_FP_A    4'hf
`define TOP8      16'h00ff
`define TOP9      16'h01ff
`define TOP10     16'h03ff
`define MAX16     16'hffff
`define ZERO16    16'h0000
`define ONE16     16'h0001
`define COM_TOG   2'h1
`define COM_CLR   2'h2
`define COM_SET   2'h3

// ------------------------------------------------------------
// Prescaler selects and terminal counts (factor minus one)
// ------------------------------------------------------------
`define CS_1      3'h1
`define CS_8      3'h2
`define CS_64     3'h3
`define CS_256    3'h4
`define CS_1024   3'h5
`define PS_8      10'h007
`define PS_64     10'h03f
`define PS_256    10'h0ff
`define PS_1024   10'h3ff
`define PS_ONE    10'h001
`define PS_ZERO   10'h000

`endif

/* File: design/timer16_pkg.sv */
// Types shared by the 16-bit PWM timer
`include "timer16_cfg.svh"
package timer16_pkg;

    // Pad drive pair: level and output enable
    typedef struct packed {
        logic out;
        logic oe;
    } pad_type;

    // Whole state of the timer block
    typedef struct packed {
        logic [`CTRL_W-1:0] ctrl;
        logic [15:0]        cnt;
        logic [15:0]        cmpa_act;
        logic [15:0]        cmpa_buf;
        logic [15:0]        cmpb;
        logic [15:0]        captop;
        logic [3:0]         flags;
        logic [9:0]         presc;
        logic               oc_a;
        logic               oc_b;
        pad_type            pad_a;
        pad_type            pad_b;
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
    } state_type;

endpackage

/* File: tb/testbench.sv */
// Self-checking testbench for the 16-bit clear-on-match and fast PWM timer
`timescale 1ns/10ps
`default_nettype none
`include "timer16_cfg.svh"
module testbench;
    import timer16_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    pad_type     pad_a;
    pad_type     pad_b;
    int          error_cnt;
    int          checks_done;
    logic [31:0] v;
    logic        err;

    // ------------------------------------------------------------
    // Device, clock and watchdog
    // ------------------------------------------------------------
    timer16_ctc_fast_pwm timer16_ctc_fast_pwm_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pad_a(pad_a), .pad_b(pad_b));

    // 20 ns period
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // Whole run needs about 17k cycles; cut off at 50k
    initial begin
        #1000000;
        error_cnt++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        wrap_up();
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s: %h vs %h", $time, what, seen, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) chk(32'h0, 32'h1, "no pready");
        v = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Same output mode and direction on both channels keeps calls short
    function automatic logic [31:0] ctl(input logic [3:0] m, input logic [1:0] com,
                                        input logic [2:0] cs, input logic d);
        return {19'h0, d, d, cs, com, com, m};
    endfunction

    // Counts pad edges and high cycles over a window
    task automatic tally(input int cyc, output int ta, output int tb, output int hi);
        logic pa;
        logic pb;
        ta = 0;
        tb = 0;
        hi = 0;
        pa = pad_a.out;
        pb = pad_b.out;
        repeat (cyc) begin
            @(posedge pclk);
            ta += int'(pad_a.out !== pa);
            tb += int'(pad_b.out !== pb);
            hi += int'(pad_a.out === 1'b1);
            pa = pad_a.out;
            pb = pad_b.out;
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Clear-on-match square wave; a window of 8 half periods must hold 8 edges
    // Compares are loaded in CTC so they act at once; channel B toggles only in CTC
    task automatic t_wave(input logic [2:0] cs, input int n, input logic [15:0] cmp,
                          input logic [1:0] com, input logic d, input logic [3:0] m);
        int ta, tb, hi, e, eb;
        apb(1'b1, `A_CTRL, ctl(`M_CTC_A, 2'h0, 3'h0, 1'b0));
        apb(1'b1, `A_COUNT, 32'h0);
        apb(1'b1, `A_CMPA, {16'h0, cmp});
        apb(1'b1, `A_CMPB, {16'h0, cmp});
        apb(1'b1, `A_CTRL, ctl(m, com, cs, d));
        repeat (n * (cmp + 1) * 2 + 4) @(posedge pclk);
        tally(n * (cmp + 1) * 8, ta, tb, hi);
        e = (com == `COM_TOG && d) ? 8 : 0;
        eb = (m == `M_CTC_A) ? e : 0;
        chk(32'(ta), 32'(e), "edges on pad a");
        chk(32'(tb), 32'(eb), "edges on pad b");
        chk({31'h0, pad_a.oe}, {31'h0, d}, "pad a enable");
        chk({31'h0, pad_b.oe}, {31'h0, d}, "pad b enable");
        if (com[1] && m == `M_CTC_A) begin
            chk({30'h0, pad_a.out, pad_b.out}, {30'h0, {2{com[0] & d}}}, "held level");
        end
        // Clear while a match fires every cycle: the flag must stay up
        if (n == 1 && cmp == 16'h0) begin
            apb(1'b1, `A_FLAGS, 32'hf);
            apb(1'b0, `A_FLAGS, 32'h0);
            chk({31'h0, v[`B_CMPA]}, 32'h1, "flag set beats clear");
        end
    endtask

    // Fast PWM duty on output A, fixed or capture TOP, with a masked compare write
    task automatic t_pwm(input logic [3:0] m, input logic [1:0] com, input int exp_hi);
        int ta, tb, hi;
        apb(1'b1, `A_CTRL, ctl(m, 2'h0, 3'h0, 1'b0));
        apb(1'b1, `A_CAPTOP, 32'hff);
        apb(1'b1, `A_CMPA, 32'h1234);
        apb(1'b0, `A_CMPA, 32'h0);
        chk(v, (m == `M_FP8) ? 32'h34 : 32'h1234, "masked compare");
        apb(1'b1, `A_CMPA, 32'h34);
        apb(1'b1, `A_COUNT, 32'h0);
        apb(1'b1, `A_CTRL, ctl(m, com, `CS_1, 1'b1));
        repeat (600) @(posedge pclk);
        tally(256, ta, tb, hi);
        chk(32'(hi), 32'(exp_hi), "pwm high time");
    endtask

    // Every CTC and fast PWM mode clears after its top and raises the matching flags
    task automatic t_tops();
        logic [3:0]  md [7] = '{`M_CTC_I, `M_CTC_A, `M_FP_I, `M_FP_A, `M_FP8, `M_FP9, `M_FP10};
        logic [15:0] tp [7] = '{16'h0020, 16'h0020, 16'h0020, 16'h0020, `TOP8, `TOP9, `TOP10};
        logic [3:0]  fm [7] = '{4'h8, 4'h2, 4'h9, 4'h3, 4'h1, 4'h1, 4'h1};
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, `A_CTRL, ctl(md[i], 2'h0, 3'h0, 1'b0));
            apb(1'b1, `A_CAPTOP, 32'h20);
            apb(1'b1, `A_CMPA, 32'h20);
            apb(1'b1, `A_CMPB, 32'h30);
            apb(1'b1, `A_COUNT, {16'h0, tp[i] - 16'h2});
            apb(1'b1, `A_FLAGS, 32'hf);
            apb(1'b0, `A_COUNT, 32'h0);
            chk(v, {16'h0, tp[i] - 16'h2}, "stopped count");
            apb(1'b1, `A_CTRL, ctl(md[i], 2'h0, `CS_1, 1'b0));
            repeat (6) @(posedge pclk);
            apb(1'b0, `A_COUNT, 32'h0);
            chk({31'h0, v < 32'h10}, 32'h1, "restart after top");
            apb(1'b0, `A_FLAGS, 32'h0);
            chk(v & {28'h0, fm[i] | 4'h4}, {28'h0, fm[i]}, "flags at top");
        end
    endtask

    // Top written below the count: run through the maximum and wrap first
    task automatic t_wrap(input logic [3:0] m, input logic [3:0] fmask);
        apb(1'b1, `A_CTRL, ctl(m, 2'h0, 3'h0, 1'b0));
        apb(1'b1, `A_CMPA, 32'h5);
        apb(1'b1, `A_CAPTOP, 32'h5);
        apb(1'b1, `A_COUNT, 32'hfff0);
        apb(1'b1, `A_FLAGS, 32'hf);
        apb(1'b1, `A_CTRL, ctl(m, 2'h0, `CS_1, 1'b0));
        repeat (30) @(posedge pclk);
        apb(1'b0, `A_COUNT, 32'h0);
        chk({31'h0, v < 32'h6}, 32'h1, "count after wrap");
        apb(1'b0, `A_FLAGS, 32'h0);
        chk(v & {28'h0, fmask}, {28'h0, fmask}, "wrap flags");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        error_cnt = 0;
        checks_done = 0;
        repeat (8) @(posedge pclk);
        chk({28'h0, pad_a, pad_b}, 32'h0, "pads in reset");
        presetn <= 1'b1;
        apb(1'b0, `A_CTRL, 32'h0);
        chk(v, 32'h0, "control after reset");
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped refused");
        t_wave(`CS_1, 1, 16'h0, `COM_TOG, 1'b1, `M_CTC_A);
        t_wave(`CS_8, 8, 16'h0, `COM_TOG, 1'b1, `M_CTC_A);
        t_wave(`CS_64, 64, 16'h0, `COM_TOG, 1'b1, `M_CTC_A);
        t_wave(`CS_256, 256, 16'h0, `COM_TOG, 1'b1, `M_CTC_A);
        t_wave(`CS_1024, 1024, 16'h0, `COM_TOG, 1'b1, `M_CTC_A);
        t_wave(`CS_1, 1, 16'h3, `COM_TOG, 1'b1, `M_CTC_A);
        t_wave(`CS_8, 8, 16'h3, `COM_TOG, 1'b1, `M_CTC_A);
        t_wave(`CS_1, 1, 16'h0, `COM_TOG, 1'b0, `M_CTC_A);
        t_wave(`CS_1, 1, 16'h0, 2'h0, 1'b1, `M_CTC_A);
        t_wave(`CS_1, 1, 16'h0, `COM_CLR, 1'b1, `M_CTC_A);
        t_wave(`CS_1, 1, 16'h0, `COM_SET, 1'b1, `M_CTC_A);
        t_wave(`CS_1, 1, 16'h3, `COM_TOG, 1'b1, `M_FP_A);
        t_pwm(`M_FP8, `COM_CLR, 'h35);
        t_pwm(`M_FP8, `COM_SET, 'hcb);
        t_pwm(`M_FP_I, `COM_CLR, 'h35);
        t_tops();
        t_wrap(`M_CTC_I, 4'h9);
        t_wrap(`M_CTC_A, 4'h3);
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
